// ==== acmc_pkg.sv ====
// Package: constants, codes and types for the audio clock mode control block
// Assumes: included before every acmc module
`default_nettype none
package acmc_pkg;

  // ---------------------------------------------------------------------
  // Clock and timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned LOCK_FS_MS       = 160;
  localparam int unsigned LOCK_BCK_MS      = 4;
  localparam int unsigned LOCK_MCK_MS      = 40;
  localparam int unsigned CYC_PER_MS       = CLK_MHZ * 1000;
  localparam int unsigned LOCK_FS_CYC      = LOCK_FS_MS * CYC_PER_MS;
  localparam int unsigned LOCK_BCK_CYC     = LOCK_BCK_MS * CYC_PER_MS;
  localparam int unsigned LOCK_MCK_CYC     = LOCK_MCK_MS * CYC_PER_MS;
  localparam int unsigned ADC_START_FRAMES = 1059;
  localparam int unsigned LOCK_W           = 25;
  localparam int unsigned FRAME_W          = 11;

  // ---------------------------------------------------------------------
  // Reference selector codes
  // ---------------------------------------------------------------------
  localparam logic [3:0] REF_FS_1     = 4'h0;
  localparam logic [3:0] REF_NA_1     = 4'h1;
  localparam logic [3:0] REF_BCK_32   = 4'h2;
  localparam logic [3:0] REF_BCK_64   = 4'h3;
  localparam logic [3:0] REF_MCK_12   = 4'h6;
  localparam logic [3:0] REF_MCK_24   = 4'h7;
  localparam logic [3:0] REF_MCK_13P5 = 4'hc;
  localparam logic [3:0] REF_MCK_27   = 4'hd;

  // ---------------------------------------------------------------------
  // Output ratio codes and divider halves (in divider ticks, 512 per frame clock period)
  // ---------------------------------------------------------------------
  localparam logic [1:0] MCO_256 = 2'h0;
  localparam logic [1:0] MCO_128 = 2'h1;
  localparam logic [1:0] MCO_64  = 2'h2;
  localparam logic [1:0] MCO_32  = 2'h3;

  localparam logic [9:0] HALF_FS   = 10'h100;
  localparam logic [9:0] HALF_B32  = 10'h008;
  localparam logic [9:0] HALF_B64  = 10'h004;
  localparam logic [9:0] HALF_M256 = 10'h001;

  // ---------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {ACMC_EXT_SLAVE, ACMC_EXT_MASTER, ACMC_PLL_SLAVE,
                            ACMC_PLL_MASTER} acmc_mode_t;

  typedef enum logic [1:0] {ACMC_SRC_NONE, ACMC_SRC_FS, ACMC_SRC_BCK,
                            ACMC_SRC_MCK} acmc_src_t;

  typedef enum logic [1:0] {ACMC_PLL_OFF, ACMC_PLL_WAIT, ACMC_PLL_LOCKED,
                            ACMC_PLL_BAD} acmc_pll_t;

endpackage : acmc_pkg
`default_nettype wire

// ==== acmc_sync.sv ====
// Three-stage pin synchroniser with second/third agreement
// Assumes: input is asynchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none
module acmc_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic clk_en,
  // Pin and result
  input  wire logic pin_in,
  output logic      level_q
);

  logic [2:0] stage_q;
  logic [2:0] stage_d;
  logic       level_d;

  // ---------------------------------------------------------------------
  // Next values
  // ---------------------------------------------------------------------
  always_comb
  begin
    stage_d = {stage_q[1:0], pin_in};
    level_d = level_q;
    if (stage_q[2] == stage_q[1])
    begin
      level_d = stage_q[2];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      stage_q <= 3'h0;
      level_q <= 1'b0;
    end
    else if (clk_en)
    begin
      stage_q <= stage_d;
      level_q <= level_d;
    end
  end

endmodule // acmc_sync
`default_nettype wire

// ==== acmc_div.sv ====
// Toggle divider driven by a tick, with enable and forced low
// Assumes: tick is one clk_sys cycle wide
`timescale 1ns/1ps
`default_nettype none
module acmc_div #(
  parameter int unsigned W = 10
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // Control
  input  wire logic         run,
  input  wire logic         tick,
  input  wire logic [W-1:0] half,
  // Output
  output logic              clk_q,
  output logic              rise
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         clk_d;

  always_comb
  begin
    cnt_d = cnt_q;
    clk_d = clk_q;
    rise  = 1'b0;
    if (!run)
    begin
      cnt_d = '0;
      clk_d = 1'b0;
    end
    else if (tick)
    begin
      if (cnt_q + W'(1) >= half)
      begin
        cnt_d = '0;
        clk_d = ~clk_q;
        rise  = ~clk_q;
      end
      else
      begin
        cnt_d = cnt_q + W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      cnt_q <= '0;
      clk_q <= 1'b0;
    end
    else if (clk_en)
    begin
      cnt_q <= cnt_d;
      clk_q <= clk_d;
    end
  end

endmodule // acmc_div
`default_nettype wire

// ==== acmc_top.sv ====
// Clock mode control: mode select, PLL lock model, clock pins, ADC start
// Assumes: registers sit behind a plain strobe port; pins synchronised here
//
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module acmc_top #(
  parameter int unsigned LOCK_FS_CYCLES  = acmc_pkg::LOCK_FS_CYC,
  parameter int unsigned LOCK_BCK_CYCLES = acmc_pkg::LOCK_BCK_CYC,
  parameter int unsigned LOCK_MCK_CYCLES = acmc_pkg::LOCK_MCK_CYC,
  parameter int unsigned TICK_DIV        = 16
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic       clk_en,
  input  wire logic       power_down_n,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Clock pins
  input  wire logic       frame_clock_in,
  output logic            frame_clock_out,
  output logic            frame_clock_oe_n,
  input  wire logic       bit_clock_in,
  output logic            bit_clock_out,
  output logic            bit_clock_oe_n,
  input  wire logic       master_clock_in,
  output logic            master_clock_out,
  // Status
  output logic            serial_data_out_valid
);

  // ---------------------------------------------------------------------
  // Register offsets and fields
  // ---------------------------------------------------------------------
  localparam logic [3:0] A_POWER  = 4'h0;
  localparam logic [3:0] A_MODE   = 4'h1;
  localparam logic [3:0] A_RATE   = 4'h2;
  localparam logic [3:0] A_STATUS = 4'h3;
  localparam int B_PLL = 0;
  localparam int B_MS  = 1;
  localparam int B_MCE = 2;
  localparam int B_BCR = 3;
  localparam int B_VCM = 0;
  localparam int B_ADL = 1;
  localparam int B_ADR = 2;
  localparam int B_DAC = 3;

  // ---------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------
  logic       rst_ok;
  logic [3:0] pwr_q, pwr_d;
  logic [3:0] mode_q, mode_d;
  logic [3:0] ref_q, ref_d;
  logic [3:0] rate_q, rate_d;
  logic [1:0] mco_q, mco_d;
  logic [7:0] rdata_d;
  logic       locked;
  acmc_pkg::acmc_mode_t cur_mode;

  assign rst_ok = rst_b & power_down_n;

  always_comb
  begin
    pwr_d   = pwr_q;
    mode_d  = mode_q;
    ref_d   = ref_q;
    rate_d  = rate_q;
    mco_d   = mco_q;
    rdata_d = 8'h00;
    if (reg_wr)
    begin
      if (reg_addr == A_POWER)
      begin
        pwr_d = reg_wdata[3:0];
      end
      else if (reg_addr == A_MODE)
      begin
        mode_d = reg_wdata[3:0];
        mco_d  = reg_wdata[5:4];
      end
      else if (reg_addr == A_RATE)
      begin
        ref_d  = reg_wdata[3:0];
        rate_d = reg_wdata[7:4];
      end
    end
    if (reg_rd)
    begin
      if (reg_addr == A_POWER)
      begin
        rdata_d = {4'h0, pwr_q};
      end
      else if (reg_addr == A_MODE)
      begin
        rdata_d = {2'h0, mco_q, mode_q};
      end
      else if (reg_addr == A_RATE)
      begin
        rdata_d = {rate_q, ref_q};
      end
      else if (reg_addr == A_STATUS)
      begin
        rdata_d = {3'h0, serial_data_out_valid, locked, mode_q[B_MS], cur_mode};
      end
    end
  end

  // ---------------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------------
  acmc_pkg::acmc_src_t  src;
  logic                 pll_on, master, pll_mode;

  function automatic acmc_pkg::acmc_src_t ref_decode(input logic [3:0] code);
    case (code)
      acmc_pkg::REF_FS_1:     ref_decode = acmc_pkg::ACMC_SRC_FS;
      acmc_pkg::REF_BCK_32,
      acmc_pkg::REF_BCK_64:   ref_decode = acmc_pkg::ACMC_SRC_BCK;
      acmc_pkg::REF_MCK_12,
      acmc_pkg::REF_MCK_24,
      acmc_pkg::REF_MCK_13P5,
      acmc_pkg::REF_MCK_27:   ref_decode = acmc_pkg::ACMC_SRC_MCK;
      default:                ref_decode = acmc_pkg::ACMC_SRC_NONE;
    endcase
  endfunction

  always_comb
  begin
    pll_on   = mode_q[B_PLL];
    master   = mode_q[B_MS];
    pll_mode = pll_on;
    src      = ref_decode(ref_q);
    case ({pll_on, master})
      2'b11:   cur_mode = acmc_pkg::ACMC_PLL_MASTER;
      2'b10:   cur_mode = acmc_pkg::ACMC_PLL_SLAVE;
      2'b01:   cur_mode = acmc_pkg::ACMC_EXT_MASTER;
      default: cur_mode = acmc_pkg::ACMC_EXT_SLAVE;
    endcase
  end

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  logic fs_s, bck_s, mck_s, fs_prev_q;

  acmc_sync u_sync_fs (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                       .pin_in(frame_clock_in), .level_q(fs_s));
  acmc_sync u_sync_bck (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                        .pin_in(bit_clock_in), .level_q(bck_s));
  acmc_sync u_sync_mck (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                        .pin_in(master_clock_in), .level_q(mck_s));

  // ---------------------------------------------------------------------
  // PLL lock model
  // ---------------------------------------------------------------------
  acmc_pkg::acmc_pll_t     pll_q, pll_d;
  logic [acmc_pkg::LOCK_W-1:0] lock_cnt_q, lock_cnt_d, lock_lim;
  logic [3:0]              ref_prev_q;
  logic [3:0]              rate_prev_q;
  logic                    retune;

  always_comb
  begin
    case (src)
      acmc_pkg::ACMC_SRC_FS:  lock_lim = acmc_pkg::LOCK_W'(LOCK_FS_CYCLES);
      acmc_pkg::ACMC_SRC_BCK: lock_lim = acmc_pkg::LOCK_W'(LOCK_BCK_CYCLES);
      default:                lock_lim = acmc_pkg::LOCK_W'(LOCK_MCK_CYCLES);
    endcase
    retune     = (ref_prev_q != ref_q) || (rate_prev_q != rate_q);
    pll_d      = pll_q;
    lock_cnt_d = lock_cnt_q;
    case (pll_q)
      acmc_pkg::ACMC_PLL_OFF:
      begin
        lock_cnt_d = '0;
        if (pll_on)
        begin
          pll_d = acmc_pkg::ACMC_PLL_WAIT;
        end
      end
      acmc_pkg::ACMC_PLL_WAIT:
      begin
        lock_cnt_d = lock_cnt_q + acmc_pkg::LOCK_W'(1);
        if (src == acmc_pkg::ACMC_SRC_NONE)
        begin
          pll_d = acmc_pkg::ACMC_PLL_BAD;
        end
        else if (lock_cnt_d >= lock_lim)
        begin
          pll_d = acmc_pkg::ACMC_PLL_LOCKED;
        end
      end
      acmc_pkg::ACMC_PLL_LOCKED:
      begin
        if (retune)
        begin
          pll_d      = acmc_pkg::ACMC_PLL_WAIT;
          lock_cnt_d = '0;
        end
      end
      default:
      begin
        lock_cnt_d = '0;
        if (src != acmc_pkg::ACMC_SRC_NONE)
        begin
          pll_d = acmc_pkg::ACMC_PLL_WAIT;
        end
      end
    endcase
    if (!pll_on)
    begin
      pll_d      = acmc_pkg::ACMC_PLL_OFF;
      lock_cnt_d = '0;
    end
  end

  assign locked = (pll_q == acmc_pkg::ACMC_PLL_LOCKED);

  // ---------------------------------------------------------------------
  // Clock generation: ticks from the master clock input or clk_sys
  // ---------------------------------------------------------------------
  logic [7:0] tick_cnt_q, tick_cnt_d;
  logic       mck_prev_q, tick, gen_run, mco_run, fs_gen, bck_gen, mco_gen;
  logic [9:0] bck_half, mco_half;
  logic       fs_rise_gen;

  always_comb
  begin
    tick_cnt_d = tick_cnt_q;
    tick       = 1'b0;
    if (pll_mode)
    begin
      tick_cnt_d = tick_cnt_q + 8'h01;
      if (tick_cnt_q >= 8'(TICK_DIV - 1))
      begin
        tick_cnt_d = 8'h00;
        tick       = 1'b1;
      end
    end
    else
    begin
      tick = mck_s & ~mck_prev_q;
    end
    bck_half = mode_q[B_BCR] ? acmc_pkg::HALF_B64 : acmc_pkg::HALF_B32;
    case (mco_q)
      acmc_pkg::MCO_256: mco_half = acmc_pkg::HALF_M256;
      acmc_pkg::MCO_128: mco_half = 10'(acmc_pkg::HALF_M256 << 1);
      acmc_pkg::MCO_64:  mco_half = acmc_pkg::HALF_B64;
      default:           mco_half = acmc_pkg::HALF_B32;
    endcase
    gen_run = master && (pll_on ? locked : pwr_q[B_VCM] | (|pwr_q[3:1]));
    mco_run = mode_q[B_MCE] && (locked || (master && !pll_on));
  end

  acmc_div u_div_fs (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                     .run(gen_run), .tick(tick), .half(acmc_pkg::HALF_FS),
                     .clk_q(fs_gen), .rise(fs_rise_gen));
  acmc_div u_div_bck (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                      .run(gen_run), .tick(tick), .half(bck_half),
                      .clk_q(bck_gen), .rise());
  acmc_div u_div_mco (.clk_sys(clk_sys), .rst_b(rst_ok), .clk_en(clk_en),
                      .run(mco_run), .tick(tick), .half(mco_half),
                      .clk_q(mco_gen), .rise());

  // ---------------------------------------------------------------------
  // ADC start count on frame clock rises
  // ---------------------------------------------------------------------
  logic [acmc_pkg::FRAME_W-1:0] frame_cnt_q, frame_cnt_d;
  logic                         adc_on, fs_rise, valid_d;

  always_comb
  begin
    adc_on      = pwr_q[B_ADL] | pwr_q[B_ADR];
    fs_rise     = master ? fs_rise_gen : (fs_s & ~fs_prev_q);
    frame_cnt_d = frame_cnt_q;
    valid_d     = serial_data_out_valid;
    if (!adc_on)
    begin
      frame_cnt_d = '0;
      valid_d     = 1'b0;
    end
    else if (fs_rise && !serial_data_out_valid)
    begin
      frame_cnt_d = frame_cnt_q + acmc_pkg::FRAME_W'(1);
      if (frame_cnt_d == acmc_pkg::FRAME_W'(acmc_pkg::ADC_START_FRAMES))
      begin
        valid_d = 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_ok)
    begin
      pwr_q                 <= 4'h0;
      mode_q                <= 4'h0;
      ref_q                 <= acmc_pkg::REF_FS_1;
      rate_q                <= 4'h0;
      mco_q                 <= acmc_pkg::MCO_256;
      reg_rdata             <= 8'h00;
      pll_q                 <= acmc_pkg::ACMC_PLL_OFF;
      lock_cnt_q            <= '0;
      ref_prev_q            <= 4'h0;
      rate_prev_q           <= 4'h0;
      tick_cnt_q            <= 8'h00;
      mck_prev_q            <= 1'b0;
      fs_prev_q             <= 1'b0;
      frame_cnt_q           <= '0;
      serial_data_out_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      pwr_q                 <= pwr_d;
      mode_q                <= mode_d;
      ref_q                 <= ref_d;
      rate_q                <= rate_d;
      mco_q                 <= mco_d;
      reg_rdata             <= rdata_d;
      pll_q                 <= pll_d;
      lock_cnt_q            <= lock_cnt_d;
      ref_prev_q            <= ref_q;
      rate_prev_q           <= rate_q;
      tick_cnt_q            <= tick_cnt_d;
      mck_prev_q            <= mck_s;
      fs_prev_q             <= fs_s;
      frame_cnt_q           <= frame_cnt_d;
      serial_data_out_valid <= valid_d;
    end
  end

  // ---------------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------------
  assign frame_clock_out  = fs_gen;
  assign bit_clock_out    = bck_gen;
  assign frame_clock_oe_n = ~master;
  assign bit_clock_oe_n   = ~master;
  assign master_clock_out = mco_gen;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  property p_slave_tristate;
    @(posedge clk_sys) disable iff (!rst_ok)
    !mode_q[B_MS] |-> (frame_clock_oe_n && bit_clock_oe_n);
  endproperty
  a_slave_tristate: assert property (p_slave_tristate)
    else $error("Slave mode drives clock pins");

  property p_mco_off;
    @(posedge clk_sys) disable iff (!rst_ok)
    !mode_q[B_MCE] |=> !master_clock_out;
  endproperty
  a_mco_off: assert property (p_mco_off)
    else $error("Master clock out not low when disabled");

  property p_prelock_low;
    @(posedge clk_sys) disable iff (!rst_ok)
    (pll_on && pll_q == acmc_pkg::ACMC_PLL_WAIT) |=> (!frame_clock_out && !bit_clock_out);
  endproperty
  a_prelock_low: assert property (p_prelock_low)
    else $error("Clocks toggle before lock");

  property p_bad_nolock;
    @(posedge clk_sys) disable iff (!rst_ok)
    (src == acmc_pkg::ACMC_SRC_NONE) |=> !locked;
  endproperty
  a_bad_nolock: assert property (p_bad_nolock)
    else $error("Locked with unsupported selector");

  property p_reset_slave;
    @(posedge clk_sys)
    !rst_ok |=> (cur_mode == acmc_pkg::ACMC_EXT_SLAVE);
  endproperty
  a_reset_slave: assert property (p_reset_slave)
    else $error("Not slave after reset");

  property p_mode_map;
    @(posedge clk_sys) disable iff (!rst_ok)
    (mode_q[B_PLL] && mode_q[B_MS]) |-> (cur_mode == acmc_pkg::ACMC_PLL_MASTER);
  endproperty
  a_mode_map: assert property (p_mode_map)
    else $error("Mode decode wrong");

  property p_valid_needs_adc;
    @(posedge clk_sys) disable iff (!rst_ok)
    (!pwr_q[B_ADL] && !pwr_q[B_ADR]) |=> !serial_data_out_valid;
  endproperty
  a_valid_needs_adc: assert property (p_valid_needs_adc)
    else $error("Data valid without ADC power");

  property p_valid_count;
    @(posedge clk_sys) disable iff (!rst_ok)
    $rose(serial_data_out_valid) |->
      (frame_cnt_q == acmc_pkg::FRAME_W'(acmc_pkg::ADC_START_FRAMES));
  endproperty
  a_valid_count: assert property (p_valid_count)
    else $error("Data valid at wrong frame count");

  property p_lock_time;
    @(posedge clk_sys) disable iff (!rst_ok)
    $rose(locked) |-> (lock_cnt_q >= lock_lim - acmc_pkg::LOCK_W'(1));
  endproperty
  a_lock_time: assert property (p_lock_time)
    else $error("Lock before time");

  c_lock: cover property (@(posedge clk_sys) disable iff (!rst_ok) $rose(locked));
  c_valid: cover property (@(posedge clk_sys) disable iff (!rst_ok)
    $rose(serial_data_out_valid));
  c_master: cover property (@(posedge clk_sys) disable iff (!rst_ok) $rose(frame_clock_out));

endmodule // acmc_top
`default_nettype wire

// ==== acmc_host.sv ====
// Host clock source: master, bit and frame clocks
// Assumes: en high while frames run
`timescale 1ns/1ps
`default_nettype none
module acmc_host (
  // Control
  input  wire logic en,
  // Clocks
  output logic      mck,
  output logic      bck,
  output logic      frame_clock
);
  initial
  begin
    mck = 1'b0;
    bck = 1'b0;
    frame_clock = 1'b0;
    #1.3;
    forever
    begin
      #20;
      mck = en & ~mck;
    end
  end
  always @(posedge mck) bck <= ~bck;
  // Frame edges on bit falls only
  always @(negedge bck) frame_clock <= ~frame_clock;
endmodule // acmc_host
`default_nettype wire

// ==== audio_clock_mode_control_test.sv ====
// Bench for clock mode control: modes, lock, clocks, ADC start
// Assumes: acmc_host feeds the clock pins in slave modes
`timescale 1ns/1ps
`default_nettype none
module audio_clock_mode_control_test;
  localparam logic [15:0] SUP = 16'h30cd;
  logic       clk_sys, rst_b, power_down_n, reg_wr, reg_rd, host_en, clk_en, pb, pm;
  logic       fco, fco_oe_n, bco, bco_oe_n, mco, valid, hm, hb, hf, p, v0;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rd_q, m;
  int         fails, n_compared, seed, i, n, k, cb, cm;
  wire        fci = fco_oe_n ? hf : fco;
  wire        bci = bco_oe_n ? hb : bco;

  acmc_host acmc_host_i (.en(host_en), .mck(hm), .bck(hb), .frame_clock(hf));
  acmc_top #(.LOCK_FS_CYCLES(50), .LOCK_BCK_CYCLES(50), .LOCK_MCK_CYCLES(50), .TICK_DIV(1))
  acmc_top_i (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .power_down_n(power_down_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .frame_clock_in(fci), .frame_clock_out(fco),
    .frame_clock_oe_n(fco_oe_n), .bit_clock_in(bci), .bit_clock_out(bco),
    .bit_clock_oe_n(bco_oe_n), .master_clock_in(hm), .master_clock_out(mco),
    .serial_data_out_valid(valid));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] half_rises(input int fs_mult);
    half_rises = 8'(fs_mult / 2);
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [3:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_q = reg_rdata;
    @(posedge clk_sys);
  endtask
  task automatic wait_hi(input int w, input int lim);
    n = 0;
    while ((w == 0 ? fco : mco) !== 1'b1 && n < lim)
    begin
      @(posedge clk_sys);
      n++;
    end
    check({7'h0, n < lim}, 8'h01);
    if (n >= lim) stop_test;
  endtask

  initial
  begin
    seed = 32'h3302;
    fails = 0;
    n_compared = 0;
    {rst_b, reg_wr, reg_rd, host_en} = 4'h0;
    power_down_n = 1'b1;
    clk_en = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    rd(4'h3);
    check(rd_q, 8'h00);
    check({6'h0, fco_oe_n, bco_oe_n}, 8'h03);
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      m = $random(seed);
      wr(4'h1, m);
      rd(4'h3);
      check(rd_q & 8'h07, {5'h0, m[1], m[0], m[1]});
      check({7'h0, fco_oe_n}, {7'h0, ~m[1]});
    end
    $display("mode test done");
    host_en <= 1'b1;
    wr(4'h1, 8'h04);
    k = 0;
    repeat (100)
    begin
      @(posedge clk_sys);
      k += (mco !== 1'b0);
    end
    check(k[7:0], 8'h00);
    wr(4'h0, 8'h01);
    wr(4'h1, 8'h06);
    wait_hi(0, 3000);
    wait_hi(1, 3000);
    $display("external test done");
    for (i = 0; i < 16; i++)
    begin
      wr(4'h1, 8'h00);
      wr(4'h2, i[7:0]);
      wr(4'h1, 8'h07);
      rd(4'h3);
      check({6'h0, rd_q[3], fco}, 8'h00);
      repeat (60) @(posedge clk_sys);
      rd(4'h3);
      check({7'h0, rd_q[3]}, {7'h0, SUP[i]});
      if (SUP[i]) wait_hi(1, 20);
    end
    $display("lock test done");
    wr(4'h2, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(4'h1, 8'h00);
      wr(4'h1, {2'h0, i[1:0], i[0], 3'h7});
      {n, k, cb, cm} = 128'h0;
      while (fco !== 1'b1 && k < 400)
      begin
        {pb, pm} = {bco, mco};
        @(posedge clk_sys);
        k++;
      end
      while (fco === 1'b1 && n < 300)
      begin
        cb += (bco === 1'b1 && pb === 1'b0);
        cm += (mco === 1'b1 && pm === 1'b0);
        {pb, pm} = {bco, mco};
        @(posedge clk_sys);
        n++;
      end
      check({6'h0, k < 400, n < 300}, 8'h03);
      if (k >= 400 || n >= 300) stop_test;
      check(cb[7:0], half_rises(32 << i[0]));
      check(cm[7:0], half_rises(256 >> i[1:0]));
    end
    $display("ratio test done");
    wr(4'h1, 8'h00);
    wr(4'h0, 8'h02);
    {n, k, p} = {32'h0, 32'h0, hf};
    while (n < 1061 && k < 30000)
    begin
      @(posedge clk_sys);
      k++;
      n += (hf & ~p);
      p = hf;
      if (n == 1057) v0 = valid;
    end
    check({5'h0, k < 30000, v0, valid}, 8'h05);
    if (k >= 30000) stop_test;
    $display("adc start test done");
    wr(4'h1, 8'h02);
    power_down_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    power_down_n <= 1'b1;
    @(posedge clk_sys);
    rd(4'h1);
    check({rd_q[6:0], valid}, 8'h00);
    wr(4'h3, 8'hff);
    rd(4'h3);
    check(rd_q, 8'h00);
    rd(4'hf);
    check(rd_q, 8'h00);
    clk_en <= 1'b0;
    wr(4'h0, 8'h0f);
    clk_en <= 1'b1;
    rd(4'h0);
    check(rd_q, 8'h00);
    wr(4'h0, 8'h0f);
    rd(4'h0);
    check(rd_q, 8'h0f);
    $display("power down test done");
    stop_test;
  end
endmodule // audio_clock_mode_control_test
`default_nettype wire
